// *** rtl/timer_pkg.sv ***
// Shared constants for the prescaled dual timer block.
package timer_pkg;

  // ==========================================================================
  // Widths
  localparam int PRESCALE_W = 11;
  localparam int TIMER_W = 8;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int FREE_MODE_W = 3;
  localparam int RELOAD_MODE_W = 4;
  localparam int TAP_CODE_W = 3;
  localparam int TAP_LOG_W = 4;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_FREE_FLAGS = 4'h1;
  localparam logic [3:0] IDX_RELOAD_FLAGS = 4'h2;
  localparam logic [3:0] IDX_FREE_MODE = 4'h8;
  localparam logic [3:0] IDX_RELOAD_MODE = 4'h9;
  localparam logic [3:0] IDX_RELOAD_LOW = 4'hA;
  localparam logic [3:0] IDX_RELOAD_HIGH = 4'hB;

  // ==========================================================================
  // Field positions inside the flag and mask nibbles.
  localparam int FREE_FLAG_BIT = 2;
  localparam int FREE_MASK_BIT = 3;
  localparam int RELOAD_FLAG_BIT = 0;
  localparam int RELOAD_MASK_BIT = 1;

  // Reload mode nibble: bit 3 selects auto-reload, bits 2:0 the clock.
  localparam int AUTO_RELOAD_BIT = 3;
  localparam logic [TAP_CODE_W-1:0] EVENT_CODE = 3'h7;

  // ==========================================================================
  // Reset values and the counter maximum.
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 11'h000;
  localparam logic [TIMER_W-1:0] TIMER_RST = 8'h00;
  localparam logic [TIMER_W-1:0] TIMER_MAX = 8'hFF;
  localparam logic [FREE_MODE_W-1:0] FREE_MODE_RST = 3'h0;
  localparam logic [RELOAD_MODE_W-1:0] RELOAD_MODE_RST = 4'h0;
  localparam logic MASK_RST = 1'b1;

  // ==========================================================================
  // Division code to prescaler tap, as log2 of the divide ratio.
  localparam logic [7:0][TAP_LOG_W-1:0] TAP_LOG2 = {
    4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hB
  };

  // Mode writes to the reload timer take effect this many instruction
  // cycles later.
  localparam int MODE_DELAY_INSTR = 2;

  // ==========================================================================
  // Bus handshake states.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

// *** rtl/tap_tick.sv ***
// Prescaler tap decoder producing a one-cycle divided tick.
`timescale 1ns/1ps
`default_nettype none

module tap_tick #(
  parameter int PW = timer_pkg::PRESCALE_W
) (
  input wire logic [PW-1:0] prescaler,
  input wire logic [timer_pkg::TAP_CODE_W-1:0] code,
  output logic tick
);

  // ==========================================================================
  // Tap lookup
  logic [timer_pkg::TAP_LOG_W-1:0] tapLog;
  logic [PW-1:0] lowMask;

  // The code picks a divide ratio from a fixed table.
  assign tapLog = timer_pkg::TAP_LOG2[code];

  // Build a mask of the low bits below the chosen tap, one bit per entry.
  genvar i;
  generate
    for (i = 0; i < PW; i++) begin : gMask
      assign lowMask[i] = (i < int'(tapLog));
    end
  endgenerate

  // The tick fires when every bit below the tap is one, so the next
  // increment carries into it; this gives one tick per 2**tapLog clocks.
  assign tick = ((prescaler & lowMask) == lowMask);

endmodule // tap_tick

`default_nettype wire

// *** rtl/prescaled_dual_timer.sv ***
// Prescaler with free-running and auto-reload timers behind an Avalon slave.
`timescale 1ns/1ps
`default_nettype none

module prescaled_dual_timer #(
  parameter int INSTR_CLKS = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [timer_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [timer_pkg::DATA_W-1:0] writedata,
  output logic [timer_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic stopMode,
  input wire logic eventInterruptInput,
  input wire logic [timer_pkg::TAP_CODE_W-1:0] serialDivCode,
  output logic serialTick,
  output logic freeTimerIrq,
  output logic reloadTimerIrq
);

  // ==========================================================================
  // Local sizes
  localparam int DELAY_CLKS = timer_pkg::MODE_DELAY_INSTR * INSTR_CLKS;
  localparam int DELAY_W = $clog2(DELAY_CLKS + 1);
  localparam logic [DELAY_W-1:0] DELAY_LOAD = DELAY_W'(DELAY_CLKS);
  localparam logic [DELAY_W-1:0] DELAY_ONE = DELAY_W'(1);
  localparam logic [DELAY_W-1:0] DELAY_ZERO = DELAY_W'(0);
  localparam int TW = timer_pkg::TIMER_W;
  localparam int NW = timer_pkg::NIB_W;

  // ==========================================================================
  // State of the whole block
  typedef struct packed {
    timer_pkg::bus_state_t busState;
    logic waitReq;
    logic [timer_pkg::DATA_W-1:0] readData;
    logic [timer_pkg::PRESCALE_W-1:0] prescaler;
    logic [TW-1:0] freeCount;
    logic [TW-1:0] reloadCount;
    logic [TW-1:0] loadReg;
    logic [timer_pkg::FREE_MODE_W-1:0] freeTimerMode;
    logic [timer_pkg::RELOAD_MODE_W-1:0] reloadTimerMode;
    logic [timer_pkg::RELOAD_MODE_W-1:0] pendingMode;
    logic [DELAY_W-1:0] modeDelay;
    logic freeTimerRequestFlag;
    logic freeTimerMask;
    logic reloadTimerRequestFlag;
    logic reloadTimerMask;
    logic [NW-1:0] countLowLatch;
    logic eventPrev;
    logic freeIrq;
    logic reloadIrq;
    logic serialTk;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ==========================================================================
  // Tap decoders
  logic freeTapTick;
  logic reloadTapTick;
  logic serialTapTick;

  // Free timer clock comes from its own mode register.
  tap_tick #(
    .PW(timer_pkg::PRESCALE_W)
  ) uFreeTap (
    .prescaler(s_r.prescaler),
    .code(s_r.freeTimerMode),
    .tick(freeTapTick)
  );

  // Reload timer clock uses the low three bits of its mode.
  tap_tick #(
    .PW(timer_pkg::PRESCALE_W)
  ) uReloadTap (
    .prescaler(s_r.prescaler),
    .code(s_r.reloadTimerMode[timer_pkg::TAP_CODE_W-1:0]),
    .tick(reloadTapTick)
  );

  // The serial interface lives elsewhere; it only borrows a tap here.
  tap_tick #(
    .PW(timer_pkg::PRESCALE_W)
  ) uSerialTap (
    .prescaler(s_r.prescaler),
    .code(serialDivCode),
    .tick(serialTapTick)
  );

  // ==========================================================================
  // Decode helpers
  logic [3:0] regIdx;
  logic wordAligned;
  logic eventMode;
  logic eventFall;
  logic freeStep;
  logic reloadStep;
  logic freeOverflow;
  logic reloadOverflow;
  logic [timer_pkg::DATA_W-1:0] readMux;

  // The low two address bits select a byte inside the word and must be zero.
  assign regIdx = address[timer_pkg::ADDR_W-1:2];
  assign wordAligned = (address[1:0] == 2'b00);

  // Inputs are synchronous, so one stored sample is enough for edge finding.
  assign eventMode = (s_r.reloadTimerMode[timer_pkg::TAP_CODE_W-1:0] == timer_pkg::EVENT_CODE);
  assign eventFall = s_r.eventPrev & ~eventInterruptInput;

  // Both timers freeze together with the prescaler in stop mode.
  assign freeStep = freeTapTick & ~stopMode;
  assign reloadStep = (eventMode ? eventFall : reloadTapTick) & ~stopMode;
  assign freeOverflow = freeStep & (s_r.freeCount == timer_pkg::TIMER_MAX);
  assign reloadOverflow = reloadStep & (s_r.reloadCount == timer_pkg::TIMER_MAX);

  // Read multiplexer; write-only and unmapped locations read as zero.
  always_comb begin
    readMux = '0;
    if (wordAligned) begin
      unique case (regIdx)
        timer_pkg::IDX_FREE_FLAGS: begin
          readMux[timer_pkg::FREE_FLAG_BIT] = s_r.freeTimerRequestFlag;
          readMux[timer_pkg::FREE_MASK_BIT] = s_r.freeTimerMask;
        end
        timer_pkg::IDX_RELOAD_FLAGS: begin
          readMux[timer_pkg::RELOAD_FLAG_BIT] = s_r.reloadTimerRequestFlag;
          readMux[timer_pkg::RELOAD_MASK_BIT] = s_r.reloadTimerMask;
        end
        timer_pkg::IDX_RELOAD_LOW: begin
          readMux[NW-1:0] = s_r.countLowLatch;
        end
        timer_pkg::IDX_RELOAD_HIGH: begin
          readMux[NW-1:0] = s_r.reloadCount[TW-1:NW];
        end
        default: begin
          readMux = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Next-state logic
  // Order inside this process matters: count steps come first, then software
  // writes, then the overflow flag sets, so an overflow in the cycle of a
  // clearing write still leaves its flag set.
  always_comb begin
    s_nxt = s_r;

    // Prescaler runs on every system clock outside stop mode.
    if (!stopMode) begin
      s_nxt.prescaler = s_r.prescaler + 1'b1;
    end
    s_nxt.eventPrev = eventInterruptInput;

    // Free-running timer simply wraps through zero.
    if (freeStep) begin
      s_nxt.freeCount = s_r.freeCount + 1'b1;
    end

    // Reload timer reloads or clears on overflow.
    if (reloadStep) begin
      if (reloadOverflow) begin
        if (s_r.reloadTimerMode[timer_pkg::AUTO_RELOAD_BIT]) begin
          s_nxt.reloadCount = s_r.loadReg;
        end else begin
          s_nxt.reloadCount = timer_pkg::TIMER_RST;
        end
      end else begin
        s_nxt.reloadCount = s_r.reloadCount + 1'b1;
      end
    end

    // A written reload mode waits out its delay before taking hold.
    if (s_r.modeDelay != DELAY_ZERO) begin
      s_nxt.modeDelay = s_r.modeDelay - DELAY_ONE;
      if (s_r.modeDelay == DELAY_ONE) begin
        s_nxt.reloadTimerMode = s_r.pendingMode;
      end
    end

    // Bus handshake: one wait cycle, then a single-cycle answer.
    unique case (s_r.busState)
      timer_pkg::BUS_IDLE: begin
        if (read || write) begin
          s_nxt.busState = timer_pkg::BUS_ACK;
          s_nxt.waitReq = 1'b0;
          if (read) begin
            s_nxt.readData = readMux;
            // Freeze the low digit so a two-step read stays coherent.
            if (wordAligned && regIdx == timer_pkg::IDX_RELOAD_HIGH) begin
              s_nxt.countLowLatch = s_r.reloadCount[NW-1:0];
            end
          end
        end
      end
      timer_pkg::BUS_ACK: begin
        s_nxt.busState = timer_pkg::BUS_IDLE;
        s_nxt.waitReq = 1'b1;
        if (write && wordAligned) begin
          unique case (regIdx)
            timer_pkg::IDX_FREE_FLAGS: begin
              s_nxt.freeTimerRequestFlag = writedata[timer_pkg::FREE_FLAG_BIT];
              s_nxt.freeTimerMask = writedata[timer_pkg::FREE_MASK_BIT];
            end
            timer_pkg::IDX_RELOAD_FLAGS: begin
              s_nxt.reloadTimerRequestFlag = writedata[timer_pkg::RELOAD_FLAG_BIT];
              s_nxt.reloadTimerMask = writedata[timer_pkg::RELOAD_MASK_BIT];
            end
            timer_pkg::IDX_FREE_MODE: begin
              s_nxt.freeTimerMode = writedata[timer_pkg::FREE_MODE_W-1:0];
            end
            timer_pkg::IDX_RELOAD_MODE: begin
              // A second write restarts the delay with the newer value.
              s_nxt.pendingMode = writedata[timer_pkg::RELOAD_MODE_W-1:0];
              s_nxt.modeDelay = DELAY_LOAD;
            end
            timer_pkg::IDX_RELOAD_LOW: begin
              s_nxt.loadReg[NW-1:0] = writedata[NW-1:0];
            end
            timer_pkg::IDX_RELOAD_HIGH: begin
              // The high digit completes the value and loads the counter,
              // overriding any count step in the same cycle.
              s_nxt.loadReg[TW-1:NW] = writedata[NW-1:0];
              s_nxt.reloadCount = {writedata[NW-1:0], s_r.loadReg[NW-1:0]};
            end
            default: begin
              s_nxt.busState = timer_pkg::BUS_IDLE;
            end
          endcase
        end
      end
      default: begin
        s_nxt.busState = timer_pkg::BUS_IDLE;
        s_nxt.waitReq = 1'b1;
      end
    endcase

    // Overflow sets win over any clearing write in the same cycle.
    if (freeOverflow) begin
      s_nxt.freeTimerRequestFlag = 1'b1;
    end
    if (reloadOverflow) begin
      s_nxt.reloadTimerRequestFlag = 1'b1;
    end

    // Requests follow the flag and mask as they will stand next cycle.
    s_nxt.freeIrq = s_nxt.freeTimerRequestFlag & ~s_nxt.freeTimerMask;
    s_nxt.reloadIrq = s_nxt.reloadTimerRequestFlag & ~s_nxt.reloadTimerMask;
    s_nxt.serialTk = serialTapTick & ~stopMode;

    // Synchronous reset overrides everything above.
    if (rst) begin
      s_nxt = '0;
      s_nxt.busState = timer_pkg::BUS_IDLE;
      s_nxt.waitReq = 1'b1;
      s_nxt.prescaler = timer_pkg::PRESCALE_RST;
      s_nxt.freeCount = timer_pkg::TIMER_RST;
      s_nxt.reloadCount = timer_pkg::TIMER_RST;
      s_nxt.loadReg = timer_pkg::TIMER_RST;
      s_nxt.freeTimerMode = timer_pkg::FREE_MODE_RST;
      s_nxt.reloadTimerMode = timer_pkg::RELOAD_MODE_RST;
      s_nxt.pendingMode = timer_pkg::RELOAD_MODE_RST;
      s_nxt.freeTimerMask = timer_pkg::MASK_RST;
      s_nxt.reloadTimerMask = timer_pkg::MASK_RST;
      s_nxt.eventPrev = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  // Reset is folded into the next-state logic, so this stays a bare flop.
  always_ff @(posedge sys_clk) begin
    s_r <= s_nxt;
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign readdata = s_r.readData;
  assign waitrequest = s_r.waitReq;
  assign freeTimerIrq = s_r.freeIrq;
  assign reloadTimerIrq = s_r.reloadIrq;
  assign serialTick = s_r.serialTk;

endmodule // prescaled_dual_timer

`default_nettype wire

// *** bench/prescaled_dual_timer_sva.sv ***
// Port-level assertion checker for the prescaled dual timer.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
module prescaled_dual_timer_sva #(
  parameter int INSTR_CLKS = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic stopMode,
  input wire logic eventInterruptInput,
  input wire logic [2:0] serialDivCode,
  input wire logic serialTick,
  input wire logic freeTimerIrq,
  input wire logic reloadTimerIrq
);
  // All checks share the one clock and, except chk_rst_quiet, are quiet while reset is held.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Bus answers: one wait state, one cycle of acknowledge.
  chk_wait_one:
    assert property (!waitrequest |=> waitrequest) else $error("waitrequest low for more than one cycle");
  chk_ack_next:
    assert property ((read || write) && waitrequest |=> !waitrequest) else $error("request not answered");
  chk_rd_upper:
    assert property (read && !waitrequest |-> readdata[31:4] == 28'h0) else $error("readdata upper bits set");
  // Mode registers are write-only and unmapped places read as zero.
  chk_rd_mode:
    assert property (read && !waitrequest && (address == 6'h20 || address == 6'h24 || address == 6'h3C)
      |-> readdata == 32'h0) else $error("write-only or unmapped read not zero");
  // Reset must override everything, so this one is never disabled.
  chk_rst_quiet:
    assert property (disable iff (1'b0) rst |=> waitrequest && !serialTick && !freeTimerIrq && !reloadTimerIrq)
      else $error("outputs not quiet after reset");
  // The prescaler tick is a single-cycle pulse; the shortest tap gives one every two cycles.
  chk_tick_pulse:
    assert property (serialTick |=> !serialTick) else $error("serial tick longer than one cycle");
  chk_tick_period:
    assert property (serialTick && !stopMode && serialDivCode == 3'h7 ##1
      (!stopMode && serialDivCode == 3'h7) [*2] |-> serialTick) else $error("divide-by-two tick missing");
  // A set mask holds the request back; a cleared mask with the flag written lets it through.
  chk_free_mask:
    assert property (write && !waitrequest && address == 6'h04 && writedata[3] |-> ##2 !freeTimerIrq)
      else $error("masked free timer request seen");
  chk_reload_irq:
    assert property (write && !waitrequest && address == 6'h08 && writedata[1:0] == 2'b01
      |-> ##2 reloadTimerIrq) else $error("unmasked reload request missing");

  // Main scenarios reached.
  cov_read: cover property (read && !waitrequest);
  cov_free: cover property ($rose(freeTimerIrq));
  cov_reload: cover property ($rose(reloadTimerIrq));
endmodule // prescaled_dual_timer_sva

bind prescaled_dual_timer prescaled_dual_timer_sva #(.INSTR_CLKS(INSTR_CLKS)) sva_i (
  .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .stopMode(stopMode),
  .eventInterruptInput(eventInterruptInput), .serialDivCode(serialDivCode), .serialTick(serialTick),
  .freeTimerIrq(freeTimerIrq), .reloadTimerIrq(reloadTimerIrq));
`default_nettype wire

// *** bench/event_source.sv ***
// Partner model: external event pulse source on the shared interrupt pin.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Event source
module event_source (
  input wire logic sys_clk,
  output logic evPin
);
  // The pin idles high like a pulled-up active-low input; its own interrupt is masked elsewhere.
  initial evPin = 1'b1;

  // Each event is one low cycle after gap high cycles; gap above one models a slow source.
  task automatic pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk) evPin <= 1'b0;
      @(posedge sys_clk) evPin <= 1'b1;
      repeat (gap - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
  endtask
endmodule // event_source
`default_nettype wire

// *** bench/prescaled_dual_timer_tb.sv ***
// Self-checking testbench for the prescaled dual timer.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Testbench
module prescaled_dual_timer_tb;
  logic sysClk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, stopMode = 1'b0;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0;
  logic [2:0] serialDivCode = 3'h7;
  logic [31:0] readdata;
  logic waitrequest, serialTick, freeIrq, reloadIrq, evPin;
  logic [31:0] expQ[$];
  logic [7:0] v;
  int error_cnt = 0, checked = 0, seed = 32'h9A54, n;
  time t0;

  // Free-running 50 MHz clock.
  always #10 sysClk = ~sysClk;

  prescaled_dual_timer uut (.sys_clk(sysClk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .stopMode(stopMode),
    .eventInterruptInput(evPin), .serialDivCode(serialDivCode), .serialTick(serialTick),
    .freeTimerIrq(freeIrq), .reloadTimerIrq(reloadIrq));
  event_source ev (.sys_clk(sysClk), .evPin(evPin));

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Upper write data is random to show it is ignored; the request holds until acknowledged.
  task automatic bus(input logic [5:0] a, input logic wr, input logic [3:0] d);
    @(posedge sysClk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= {28'($random(seed)), d};
    n = 0;
    do begin
      @(posedge sysClk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    chk("waitrequest", {31'h0, waitrequest}, 32'h0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [3:0] e);
    expQ.push_back({28'h0, e});
    bus(a, 1'b0, 4'h0);
  endtask

  // Waits a bounded time for the free request (0) or the serial tick (1).
  task automatic waitSig(input int which, input int lim);
    n = 0;
    while (n < lim && (which == 0 ? freeIrq : serialTick) !== 1'b1) begin
      @(posedge sysClk);
      n++;
    end
  endtask

  // Each read answer is compared with the oldest noted expectation.
  always @(posedge sysClk) begin
    if (read && !waitrequest) begin
      chk("readdata", readdata, expQ.pop_front());
    end
  end

  // A hang is cut short well beyond the expected run of a few thousand cycles.
  initial begin
    #(20 * 20000);
    error_cnt++;
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    rd(6'h04, 4'h8);
    rd(6'h08, 4'h2);
    rd(6'h2C, 4'h0);
    rd(6'h28, 4'h0);
    rd(6'h20, 4'h0);
    rd(6'h24, 4'h0);
    rd(6'h3C, 4'h0);
    rd(6'h05, 4'h0);
    $display("test reset done");
    // Divide-by-two input makes the interval 512 cycles.
    bus(6'h20, 1'b1, 4'h7);
    bus(6'h04, 1'b1, 4'h0);
    waitSig(0, 700);
    t0 = $time;
    rd(6'h04, 4'h4);
    bus(6'h04, 1'b1, 4'h0);
    repeat (3) @(posedge sysClk);
    waitSig(0, 700);
    chk("overflow period", 32'(($time - t0) / 20), 32'(256 * 2));
    bus(6'h04, 1'b1, 4'hC);
    rd(6'h04, 4'hC);
    chk("free irq masked", {31'h0, freeIrq}, 32'h0);
    $display("test free timer done");
    // Event counting with auto-reload; the mode change is given time to land first.
    bus(6'h24, 1'b1, 4'hF);
    repeat (10) @(posedge sysClk);
    v = 8'($random(seed));
    bus(6'h28, 1'b1, v[3:0]);
    bus(6'h2C, 1'b1, v[7:4]);
    rd(6'h2C, v[7:4]);
    rd(6'h28, v[3:0]);
    ev.pulses(255 - int'(v), 2);
    rd(6'h2C, 4'hF);
    rd(6'h28, 4'hF);
    rd(6'h08, 4'h2);
    ev.pulses(1, 1);
    rd(6'h2C, v[7:4]);
    rd(6'h28, v[3:0]);
    rd(6'h08, 4'h3);
    bus(6'h08, 1'b1, 4'h1);
    // The request output is registered, so it is looked at one edge after the write lands.
    @(posedge sysClk);
    chk("reload irq", {31'h0, reloadIrq}, 32'h1);
    // Without auto-reload the counter wraps to zero.
    bus(6'h24, 1'b1, 4'h7);
    repeat (10) @(posedge sysClk);
    ev.pulses(256 - int'(v), 1);
    rd(6'h2C, 4'h0);
    ev.pulses(1, 1);
    rd(6'h28, 4'h0);
    stopMode <= 1'b1;
    ev.pulses(2, 1);
    stopMode <= 1'b0;
    rd(6'h2C, 4'h0);
    rd(6'h28, 4'h1);
    // A new mode is not yet in force right after its write, so an event still counts.
    bus(6'h24, 1'b1, 4'h0);
    ev.pulses(1, 1);
    rd(6'h2C, 4'h0);
    rd(6'h28, 4'h2);
    $display("test reload timer done");
    serialDivCode <= 3'($random(seed));
    waitSig(1, 2100);
    chk("serial tick", {31'h0, serialTick}, 32'h1);
    $display("test serial tick done");
    print_verdict();
  end
endmodule // prescaled_dual_timer_tb
`default_nettype wire
